// [rtl/gpio_pkg.sv]
// Package for the general-purpose pin port: register word addresses, reset values,
// carrier structs and timing counts. Assumes a 16-bit word-addressed I/O register bus.
package gpio_pkg;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned PIN_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION_LOW = 16'h1c06;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION_HIGH = 16'h1c07;
    localparam logic [ADDR_W-1:0] ADDR_PIN_INPUT_LOW = 16'h1c08;
    localparam logic [ADDR_W-1:0] ADDR_PIN_INPUT_HIGH = 16'h1c09;
    localparam logic [ADDR_W-1:0] ADDR_PIN_OUTPUT_LOW = 16'h1c0a;
    localparam logic [ADDR_W-1:0] ADDR_PIN_OUTPUT_HIGH = 16'h1c0b;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT_LOW = 16'h1c0c;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_SELECT_HIGH = 16'h1c0d;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_LOW = 16'h1c0e;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_HIGH = 16'h1c0f;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAG_LOW = 16'h1c10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAG_HIGH = 16'h1c11;
    localparam logic [ADDR_W-1:0] ADDR_PULL_DOWN_OFF_LOW = 16'h1c12;
    localparam logic [ADDR_W-1:0] ADDR_PULL_DOWN_OFF_HIGH = 16'h1c13;
    localparam logic [PIN_W-1:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [HALF_W-1:0] READ_UNMAPPED = 16'h0000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OUT_HOLD_NS = 30;
    localparam int unsigned OUT_HOLD_CYC = (OUT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IN_ACTIVE_NS = 20;
    localparam int unsigned IN_ACTIVE_CYC = (IN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIN_LAT_CYC = 5;
    localparam int unsigned FLAG_LAT_CYC = 7;
    localparam int unsigned IRQ_LAT_CYC = 8;
    localparam int unsigned HOLD_CNT_W = 3;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [HALF_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [PIN_W-1:0] direction;
        logic [PIN_W-1:0] out_data;
        logic [PIN_W-1:0] edge_select;
        logic [PIN_W-1:0] irq_enable;
        logic [PIN_W-1:0] irq_flag;
        logic [PIN_W-1:0] pull_down_off;
        logic [HALF_W-1:0] rdata;
        logic rvalid;
        logic irq;
    } regs_t;
endpackage

// [rtl/gpio_delay_line.sv]
// Fixed-length shift register for vectors of WIDTH bits, pin-wide or single-bit.
// Assumes one clock, asynchronous active-low reset and a common clock enable.
`timescale 1ns/1ps
module gpio_delay_line #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] stage;
    } line_t;

    line_t st;
    line_t next_st;

    always_comb begin
        next_st = st;
        next_st.stage[0] = i_d;
        for (int k = 1; k < DEPTH; k++) begin
            next_st.stage[k] = st.stage[k-1];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_q = st.stage[DEPTH-1];
endmodule

// [rtl/gpio_out_hold.sv]
// Per-pin output level holder: a new level is taken only after the current one has stood
// for the minimum count. Assumes one clock and a common clock enable.
`timescale 1ns/1ps
module gpio_out_hold #(
    parameter int unsigned HOLD_CYC = 3,
    parameter int unsigned CNT_W = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_want,
    output logic o_level
);
    typedef struct packed {
        logic level;
        logic [CNT_W-1:0] age;
    } hold_t;

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

    hold_t st;
    hold_t next_st;

    always_comb begin
        next_st = st;
        if (st.age != HOLD_LAST) begin
            next_st.age = st.age + 1'b1;
        end else if (i_want != st.level) begin
            next_st.level = i_want;
            next_st.age = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '{level: 1'b0, age: HOLD_LAST};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule

// [rtl/gpio_port.sv]
// 32-pin general-purpose port in two 16-bit register halves on the word-addressed I/O bus.
// Assumes pins are synchronous to i_ref_clk and the bus takes reads one cycle after request.
`timescale 1ns/1ps
module gpio_port #(
    parameter int unsigned DIN_LAT = gpio_pkg::DIN_LAT_CYC,
    parameter int unsigned FLAG_LAT = gpio_pkg::FLAG_LAT_CYC,
    parameter int unsigned IRQ_LAT = gpio_pkg::IRQ_LAT_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [gpio_pkg::ADDR_W-1:0] i_addr,
    input wire logic [gpio_pkg::HALF_W-1:0] i_wdata,
    output logic [gpio_pkg::HALF_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_irq,
    input wire logic [gpio_pkg::PIN_W-1:0] i_pin,
    output logic [gpio_pkg::PIN_W-1:0] o_pin,
    output logic [gpio_pkg::PIN_W-1:0] o_pin_oe_n,
    output logic [gpio_pkg::PIN_W-1:0] o_pull_down_en
);
    localparam int unsigned PW = gpio_pkg::PIN_W;
    localparam int unsigned HW = gpio_pkg::HALF_W;

    typedef struct packed {
        gpio_pkg::regs_t r;
        logic [PW-1:0] pin_prev;
        logic [PW-1:0] oe_n;
        logic [PW-1:0] pd_en;
        logic [PW-1:0] pin_out;
    } state_t;

    state_t st;
    state_t next_st;
    gpio_pkg::bus_req_t req;

    logic [PW-1:0] pin_din;
    logic [PW-1:0] pin_edge_src;
    logic [PW-1:0] held_level;
    logic [PW-1:0] edge_hit;
    logic irq_req;
    logic irq_late;

    assign req = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};

    // Input register view lags the pins by the polling latency less the read cycle.
    gpio_delay_line #(
        .WIDTH(PW),
        .DEPTH(DIN_LAT - 1)
    ) u_din_line (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_d(i_pin),
        .o_q(pin_din)
    );

    // Edge detection path lags so the flag lands at its latency; the request follows one later.
    gpio_delay_line #(
        .WIDTH(PW),
        .DEPTH(FLAG_LAT - 2)
    ) u_edge_line (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_d(i_pin),
        .o_q(pin_edge_src)
    );

    assign irq_req = |(st.r.irq_flag & st.r.irq_enable);

    // Request path adds the stages between the flag latency and the interrupt latency.
    gpio_delay_line #(
        .WIDTH(1),
        .DEPTH(IRQ_LAT - FLAG_LAT)
    ) u_irq_line (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_d(irq_req),
        .o_q(irq_late)
    );

    for (genvar g = 0; g < PW; g++) begin : g_hold
        gpio_out_hold #(
            .HOLD_CYC(gpio_pkg::OUT_HOLD_CYC),
            .CNT_W(gpio_pkg::HOLD_CNT_W)
        ) u_hold (
            .i_ref_clk(i_ref_clk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_want(st.r.out_data[g]),
            .o_level(held_level[g])
        );
    end

    // Edge select one picks rising, zero picks falling.
    assign edge_hit = ~st.r.direction & st.r.edge_select & pin_edge_src & ~st.pin_prev
        | ~st.r.direction & ~st.r.edge_select & ~pin_edge_src & st.pin_prev;

    always_comb begin
        logic [PW-1:0] w1c;
        logic [HW-1:0] rd_word;
        w1c = '0;
        rd_word = gpio_pkg::READ_UNMAPPED;
        next_st = st;
        next_st.pin_prev = pin_edge_src;
        if (req.wr) begin
            case (req.addr)
                gpio_pkg::ADDR_PIN_DIRECTION_LOW: next_st.r.direction[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_PIN_DIRECTION_HIGH: next_st.r.direction[PW-1:HW] = req.wdata;
                gpio_pkg::ADDR_PIN_OUTPUT_LOW: next_st.r.out_data[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_PIN_OUTPUT_HIGH: next_st.r.out_data[PW-1:HW] = req.wdata;
                gpio_pkg::ADDR_EDGE_SELECT_LOW: next_st.r.edge_select[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_EDGE_SELECT_HIGH: next_st.r.edge_select[PW-1:HW] = req.wdata;
                gpio_pkg::ADDR_IRQ_ENABLE_LOW: next_st.r.irq_enable[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_IRQ_ENABLE_HIGH: next_st.r.irq_enable[PW-1:HW] = req.wdata;
                gpio_pkg::ADDR_IRQ_FLAG_LOW: w1c[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_IRQ_FLAG_HIGH: w1c[PW-1:HW] = req.wdata;
                gpio_pkg::ADDR_PULL_DOWN_OFF_LOW: next_st.r.pull_down_off[HW-1:0] = req.wdata;
                gpio_pkg::ADDR_PULL_DOWN_OFF_HIGH: next_st.r.pull_down_off[PW-1:HW] = req.wdata;
                default: begin
                end
            endcase
        end
        // A new edge in the cycle of a clear keeps the flag set.
        next_st.r.irq_flag = (st.r.irq_flag & ~w1c) | edge_hit;
        next_st.r.irq = irq_late;
        case (req.addr)
            gpio_pkg::ADDR_PIN_DIRECTION_LOW: rd_word = st.r.direction[HW-1:0];
            gpio_pkg::ADDR_PIN_DIRECTION_HIGH: rd_word = st.r.direction[PW-1:HW];
            gpio_pkg::ADDR_PIN_INPUT_LOW: rd_word = pin_din[HW-1:0];
            gpio_pkg::ADDR_PIN_INPUT_HIGH: rd_word = pin_din[PW-1:HW];
            gpio_pkg::ADDR_PIN_OUTPUT_LOW: rd_word = st.r.out_data[HW-1:0];
            gpio_pkg::ADDR_PIN_OUTPUT_HIGH: rd_word = st.r.out_data[PW-1:HW];
            gpio_pkg::ADDR_EDGE_SELECT_LOW: rd_word = st.r.edge_select[HW-1:0];
            gpio_pkg::ADDR_EDGE_SELECT_HIGH: rd_word = st.r.edge_select[PW-1:HW];
            gpio_pkg::ADDR_IRQ_ENABLE_LOW: rd_word = st.r.irq_enable[HW-1:0];
            gpio_pkg::ADDR_IRQ_ENABLE_HIGH: rd_word = st.r.irq_enable[PW-1:HW];
            gpio_pkg::ADDR_IRQ_FLAG_LOW: rd_word = st.r.irq_flag[HW-1:0];
            gpio_pkg::ADDR_IRQ_FLAG_HIGH: rd_word = st.r.irq_flag[PW-1:HW];
            gpio_pkg::ADDR_PULL_DOWN_OFF_LOW: rd_word = st.r.pull_down_off[HW-1:0];
            gpio_pkg::ADDR_PULL_DOWN_OFF_HIGH: rd_word = st.r.pull_down_off[PW-1:HW];
            default: rd_word = gpio_pkg::READ_UNMAPPED;
        endcase
        next_st.r.rvalid = req.rd;
        if (req.rd) begin
            next_st.r.rdata = rd_word;
        end
        next_st.oe_n = ~st.r.direction;
        next_st.pin_out = held_level;
        next_st.pd_en = ~st.r.pull_down_off;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '{r: '0, pin_prev: gpio_pkg::RESET_ZERO, oe_n: ~gpio_pkg::RESET_ZERO,
                    pd_en: ~gpio_pkg::RESET_ZERO, pin_out: gpio_pkg::RESET_ZERO};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_rdata = st.r.rdata;
    assign o_rvalid = st.r.rvalid;
    assign o_irq = st.r.irq;
    assign o_pin = st.pin_out;
    assign o_pin_oe_n = st.oe_n;
    assign o_pull_down_en = st.pd_en;
endmodule

// [sim/gpio_port_sva.sv]
// Checker for the pin port: read answers, register-to-pin paths and output hold.
// Assumes it is bound to gpio_port and sees only that module's ports.
`timescale 1ns/1ps
module gpio_port_sva (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_irq,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] o_pin,
    input wire logic [31:0] o_pin_oe_n,
    input wire logic [31:0] o_pull_down_en
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    chk_read_answer: assert property (i_ce && i_rd |=> o_rvalid)
        else $error("read not answered");
    chk_no_answer: assert property (i_ce && !i_rd |=> !o_rvalid)
        else $error("answer without read");
    chk_rdata_held: assert property (!(i_ce && i_rd) |=> $stable(o_rdata))
        else $error("read data moved without read");
    chk_unmapped_zero: assert property (i_ce && i_rd && i_addr > 16'h1c13 |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_input_path: assert property (i_ce && i_rd && i_addr == gpio_pkg::ADDR_PIN_INPUT_LOW |=>
        o_rdata == $past(i_pin[15:0], 5)) else $error("input read latency wrong");
    chk_dir_to_oe: assert property (i_ce && i_wr && i_addr == gpio_pkg::ADDR_PIN_DIRECTION_LOW |->
        ##2 o_pin_oe_n[15:0] == ~$past(i_wdata, 2)) else $error("direction not on enables");
    chk_pull_switch: assert property (i_ce && i_wr && i_addr == gpio_pkg::ADDR_PULL_DOWN_OFF_LOW |->
        ##2 o_pull_down_en[15:0] == ~$past(i_wdata, 2)) else $error("pull-down not switched");
    chk_out_hold: assert property ($changed(o_pin[0]) |=> $stable(o_pin[0]) [*2])
        else $error("output level too short");
    cover property ($rose(o_irq));
    cover property ($fell(o_irq));
    cover property ($changed(o_pin[0]));
endmodule
bind gpio_port gpio_port_sva chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_rd(i_rd),
    .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_irq(o_irq), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_pull_down_en(o_pull_down_en));

// [sim/gpio_pin_world.sv]
// Far side of the pin port: outside drivers, pull-downs and the port's own drive.
// Assumes the bench chooses which pins are driven from outside and to what level.
`timescale 1ns/1ps
module gpio_pin_world (
    input wire logic i_ref_clk,
    input wire logic [31:0] i_drive_val,
    input wire logic [31:0] i_drive_en,
    input wire logic [31:0] i_port_pin,
    input wire logic [31:0] i_port_oe_n,
    input wire logic [31:0] i_pull_en,
    output logic [31:0] o_level
);
    logic toggle = 1'h0;
    always @(negedge i_ref_clk) toggle <= ~toggle;
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            if (!i_port_oe_n[k]) o_level[k] = i_port_pin[k];
            else if (i_drive_en[k]) o_level[k] = i_drive_val[k];
            else if (i_pull_en[k]) o_level[k] = 1'h0;
            else o_level[k] = toggle;
        end
    end
endmodule

// [sim/gpio_port_bench.sv]
// Self-checking bench for the pin port.
// Assumes gpio_port, gpio_pin_world and the bound checker are compiled alongside.
`timescale 1ns/1ps
module gpio_port_bench;
    logic i_ref_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic i_ce = 1'h1;
    logic i_rd = 1'h0;
    logic i_wr = 1'h0;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic [31:0] ext_val = 32'h0;
    logic [31:0] ext_en = 32'hffff_ffff;
    logic [15:0] o_rdata;
    logic o_rvalid;
    logic o_irq;
    logic [31:0] i_pin;
    logic [31:0] o_pin;
    logic [31:0] o_pin_oe_n;
    logic [31:0] o_pull_down_en;
    int errors = 0;
    int num_checks = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    gpio_port dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_rd(i_rd), .i_wr(i_wr),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_irq(o_irq),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_pull_down_en(o_pull_down_en));
    gpio_pin_world world (.i_ref_clk(i_ref_clk), .i_drive_val(ext_val), .i_drive_en(ext_en),
        .i_port_pin(o_pin), .i_port_oe_n(o_pin_oe_n), .i_pull_en(o_pull_down_en), .o_level(i_pin));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        i_wr = 1'h0;
        i_rd = 1'h0;
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_rd = 1'h0;
        i_wr = 1'h1;
        i_addr = a;
        i_wdata = d;
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
        i_wr = 1'h0;
        i_rd = 1'h1;
        i_addr = a;
        @(posedge i_ref_clk);
        #1;
        check({name, " valid"}, 32'h1, {31'h0, o_rvalid});
        check(name, {16'h0, exp}, {16'h0, o_rdata});
    endtask
    task automatic wait_irq(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (o_irq !== lvl) begin
            if (n == hi) begin
                errors++;
                $display("CHECK FAILED irq wait expected %0d seen timeout", lvl);
                tally_and_finish();
            end
            tick(1);
            n++;
        end
        check("irq delay", 32'h1, 32'(n >= lo));
    endtask
    task automatic reset_and_map;
        logic [15:0] a;
        check("oe after reset", 32'hffff_ffff, o_pin_oe_n);
        check("pull after reset", 32'hffff_ffff, o_pull_down_en);
        for (a = 16'h1c06; a <= 16'h1c13; a++) rd(a, 16'h0000, "reset value");
        rd(16'h1c20, 16'h0000, "unmapped");
        wr(gpio_pkg::ADDR_PIN_INPUT_HIGH, 16'hffff);
        rd(gpio_pkg::ADDR_PIN_INPUT_HIGH, 16'h0000, "input write ignored");
    endtask
    task automatic write_read_back;
        logic [15:0] list [10] = '{16'h1c06, 16'h1c07, 16'h1c0a, 16'h1c0b, 16'h1c0c, 16'h1c0d,
            16'h1c0e, 16'h1c0f, 16'h1c12, 16'h1c13};
        foreach (list[k]) wr(list[k], {list[k][7:0], 8'h5a});
        foreach (list[k]) rd(list[k], {list[k][7:0], 8'h5a}, "read back");
        foreach (list[k]) wr(list[k], 16'h0000);
        tick(10);
        wr(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'hffff);
        wr(gpio_pkg::ADDR_IRQ_FLAG_HIGH, 16'hffff);
        rd(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0000, "flags cleared");
    endtask
    task automatic output_hold;
        int high;
        high = 0;
        wr(gpio_pkg::ADDR_PIN_DIRECTION_LOW, 16'h0001);
        wr(gpio_pkg::ADDR_PIN_OUTPUT_LOW, 16'h0001);
        wr(gpio_pkg::ADDR_PIN_OUTPUT_LOW, 16'h0000);
        repeat (12) begin
            high += o_pin[0];
            tick(1);
        end
        check("output high width", 32'h1, 32'(high >= 3));
        check("output end level", 32'h0, {31'h0, o_pin[0]});
        wr(gpio_pkg::ADDR_PIN_DIRECTION_LOW, 16'h0000);
        tick(10);
        wr(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'hffff);
    endtask
    task automatic edge_irq;
        wr(gpio_pkg::ADDR_EDGE_SELECT_LOW, 16'h0002);
        wr(gpio_pkg::ADDR_IRQ_ENABLE_LOW, 16'h0002);
        ext_val[2] = 1'h1;
        tick(2);
        ext_val[2] = 1'h0;
        tick(10);
        rd(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0004, "falling flag");
        check("masked irq", 32'h0, {31'h0, o_irq});
        ext_val[1] = 1'h1;
        wait_irq(1'h1, 8, 10);
        ext_val[1] = 1'h0;
        rd(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0006, "rising flag");
        wr(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0002);
        wait_irq(1'h0, 1, 3);
        rd(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0004, "flag kept");
        wr(gpio_pkg::ADDR_IRQ_ENABLE_LOW, 16'h0004);
        wait_irq(1'h1, 1, 3);
        wr(gpio_pkg::ADDR_IRQ_FLAG_LOW, 16'h0004);
        wait_irq(1'h0, 1, 3);
    endtask
    task automatic poll_and_pull;
        ext_val[20] = 1'h1;
        ext_val[5] = 1'h1;
        tick(3);
        rd(gpio_pkg::ADDR_PIN_INPUT_HIGH, 16'h0000, "input too early");
        rd(gpio_pkg::ADDR_PIN_INPUT_HIGH, 16'h0010, "input seen");
        rd(gpio_pkg::ADDR_PIN_INPUT_LOW, 16'h0020, "input low seen");
        ext_en[3] = 1'h0;
        wr(gpio_pkg::ADDR_PULL_DOWN_OFF_LOW, 16'h0008);
        tick(1);
        check("pull off", 32'hffff_fff7, o_pull_down_en);
    endtask
    task automatic clock_hold;
        i_ce = 1'h0;
        wr(gpio_pkg::ADDR_PIN_DIRECTION_HIGH, 16'hffff);
        tick(2);
        check("frozen oe", 32'hffff_ffff, o_pin_oe_n);
        i_ce = 1'h1;
        rd(gpio_pkg::ADDR_PIN_DIRECTION_HIGH, 16'h0000, "frozen write dropped");
    endtask
    initial begin
        tick(2);
        i_rstn = 1'h1;
        tick(6);
        reset_and_map();
        write_read_back();
        output_hold();
        edge_irq();
        poll_and_pull();
        clock_hold();
        tally_and_finish();
    end
endmodule
